// *** hw/fpwp_map.vh ***
/*
 Register offsets, field positions, reset values and key words of the
 program-flash page write-protect block. Definitions only; included by
 the design files by bare name.
*/
`ifndef FPWP_MAP_VH
`define FPWP_MAP_VH

// register byte offsets on the plain register port
`define FPWP_OFS_PROTECT   8'h00
`define FPWP_OFS_KEY       8'h04
`define FPWP_OFS_STATUS    8'h08
`define FPWP_OFS_FAULT     8'h0C

// protect register layout
`define FPWP_UNLOCK_BIT    31
`define FPWP_FIELD_MSB     23
`define FPWP_PAGE_LSB      14
`define FPWP_FIELD_W       10
`define FPWP_FLASH_REGION  8'h1D

// reset values
`define FPWP_RST_UNLOCK    1'b1
`define FPWP_RST_FIELD     10'h000

// status register layout
`define FPWP_ST_ERR_BIT    0
`define FPWP_ST_OPEN_BIT   1
`define FPWP_ST_ERASE_BIT  2

// key words of the unlock sequence; values are arbitrary
`define FPWP_KEY_FIRST     32'h0F1E2D3C
`define FPWP_KEY_SECOND    32'hC3D2E1F0

`endif

// *** hw/fpwp_page_check.v ***
/*
 Page comparator: tells whether a physical address falls in a protected
 program-flash page. Purely combinational; the caller registers the result.
 Assumes the page field and page offset together span address bits 23:0.
*/
`timescale 1ns/1ps
`include "fpwp_map.vh"

module fpwp_page_check
#(
    parameter FIELD_W  = `FPWP_FIELD_W,
    parameter PAGE_LSB = `FPWP_PAGE_LSB
)
(
    input  wire [FIELD_W-1:0] boundary_i,
    input  wire [31:0]        addr_i,
    output wire               protected_o
);

    wire               in_flash;
    wire [FIELD_W-1:0] page;
    wire               enabled;

    assign in_flash = (addr_i[31:24] == `FPWP_FLASH_REGION);
    assign page     = addr_i[PAGE_LSB+FIELD_W-1:PAGE_LSB];
    assign enabled  = (boundary_i != {FIELD_W{1'b0}});
    assign protected_o = enabled && in_flash && (page <= boundary_i);

endmodule

// *** hw/fpwp_ctrl.v ***
/*
 Program-flash page write-protect control. Holds the protect register with
 its one-way unlock bit, the key unlock sequence that gates updates to it,
 and the filter that refuses program and erase commands aimed at protected
 pages. Assumes one clock, a single-cycle register port with read data in
 the following cycle, and a flash controller that issues one-cycle requests.
*/
// The register addresses and the plain strobed port were chosen for this implementation.
// What this block does
// - bit 31 high lets register change
// - bit 31 low freezes the register
// - software only clears bit 31; reset sets
// - bits 30 to 24 read zero
// - protect flash at and below boundary with top byte
// - zero boundary means no protection
// - whole boundary page and lower protected
// - updates only right after key sequence
`timescale 1ns/1ps
`include "fpwp_map.vh"

module fpwp_ctrl
#(
    parameter        FIELD_W    = `FPWP_FIELD_W,
    parameter        PAGE_LSB   = `FPWP_PAGE_LSB,
    parameter [31:0] KEY_FIRST  = `FPWP_KEY_FIRST,
    parameter [31:0] KEY_SECOND = `FPWP_KEY_SECOND
)
(
    input  wire        mclk_i,
    input  wire        reset_n_i,
    input  wire [7:0]  reg_addr_i,
    input  wire [31:0] reg_wdata_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    output reg  [31:0] reg_rdata_o,
    input  wire        flash_req_i,
    input  wire        flash_erase_i,
    input  wire [31:0] flash_addr_i,
    output reg         flash_go_o,
    output reg         flash_refuse_o
);

    // unlock sequence states
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_HALF = 3'b010;
    localparam [2:0] ST_OPEN = 3'b100;

    reg  [2:0]         state;
    reg  [2:0]         next_state;
    reg                unlock_bit;
    reg  [FIELD_W-1:0] boundary;
    reg                err_flag;
    reg                err_erase;
    reg  [31:0]        fault_addr;
    reg  [31:0]        next_rdata;

    wire               wr_protect;
    wire               wr_key;
    wire               wr_status;
    wire               first_key;
    wire               second_key;
    wire               take_update;
    wire               req_protected;
    wire               refuse_now;
    wire               clear_err;
    wire [31:0]        protect_word;
    wire [31:0]        status_word;

    function sel;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            sel = (addr == ofs);
        end
    endfunction

    assign wr_protect = reg_wr_i && sel(reg_addr_i, `FPWP_OFS_PROTECT);
    assign wr_key     = reg_wr_i && sel(reg_addr_i, `FPWP_OFS_KEY);
    assign wr_status  = reg_wr_i && sel(reg_addr_i, `FPWP_OFS_STATUS);
    assign first_key  = wr_key && (reg_wdata_i == KEY_FIRST);
    assign second_key = wr_key && (reg_wdata_i == KEY_SECOND);

    always @*
    begin
        next_state = state;
        if (reg_wr_i)
        begin
            case (state)
                ST_IDLE:
                begin
                    next_state = first_key ? ST_HALF : ST_IDLE;
                end
                ST_HALF:
                begin
                    if (second_key)
                    begin
                        next_state = ST_OPEN;
                    end
                    else
                    begin
                        next_state = first_key ? ST_HALF : ST_IDLE;
                    end
                end
                ST_OPEN:
                begin
                    // the open window lasts for exactly one write of any kind
                    next_state = first_key ? ST_HALF : ST_IDLE;
                end
                default:
                begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    always @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state <= ST_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign take_update = wr_protect && (state == ST_OPEN) && unlock_bit;

    always @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            unlock_bit <= `FPWP_RST_UNLOCK;
            boundary   <= `FPWP_RST_FIELD;
        end
        else if (take_update)
        begin
            unlock_bit <= unlock_bit & reg_wdata_i[`FPWP_UNLOCK_BIT];
            boundary   <= reg_wdata_i[`FPWP_FIELD_MSB:PAGE_LSB];
        end
    end

    assign protect_word = {unlock_bit, 7'h00, boundary, {PAGE_LSB{1'b0}}};

    fpwp_page_check
    #(
        .FIELD_W  (FIELD_W),
        .PAGE_LSB (PAGE_LSB)
    )
    u_page_check
    (
        .boundary_i  (boundary),
        .addr_i      (flash_addr_i),
        .protected_o (req_protected)
    );

    assign refuse_now = flash_req_i && req_protected;
    assign clear_err  = wr_status && reg_wdata_i[`FPWP_ST_ERR_BIT];

    always @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            flash_go_o     <= 1'b0;
            flash_refuse_o <= 1'b0;
        end
        else
        begin
            flash_go_o     <= flash_req_i && !req_protected;
            flash_refuse_o <= refuse_now;
        end
    end

    always @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            err_flag   <= 1'b0;
            err_erase  <= 1'b0;
            fault_addr <= 32'h00000000;
        end
        else if (refuse_now)
        begin
            err_flag   <= 1'b1;
            err_erase  <= flash_erase_i;
            fault_addr <= flash_addr_i;
        end
        else if (clear_err)
        begin
            err_flag <= 1'b0;
        end
    end

    assign status_word = {29'h00000000, err_erase, (state == ST_OPEN), err_flag};

    // read data stand only in the cycle after the strobe; unmapped reads give zero
    always @*
    begin
        next_rdata = 32'h00000000;
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                `FPWP_OFS_PROTECT:
                begin
                    next_rdata = protect_word;
                end
                `FPWP_OFS_STATUS:
                begin
                    next_rdata = status_word;
                end
                `FPWP_OFS_FAULT:
                begin
                    next_rdata = fault_addr;
                end
                default:
                begin
                    next_rdata = 32'h00000000;
                end
            endcase
        end
    end

    always @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            reg_rdata_o <= 32'h00000000;
        end
        else
        begin
            reg_rdata_o <= next_rdata;
        end
    end

endmodule

// *** tb/fpwp_ctrl_properties.sv ***
/*
 Port checker for fpwp_ctrl: flash request answers and protect readback.
 Assumes the offsets of fpwp_map.vh; bound to every fpwp_ctrl.
*/
`timescale 1ns/1ps
`include "fpwp_map.vh"
module fpwp_ctrl_properties
(
    input wire        mclk_i,
    input wire        reset_n_i,
    input wire [7:0]  reg_addr_i,
    input wire        reg_rd_i,
    input wire [31:0] reg_rdata_o,
    input wire        flash_req_i,
    input wire [31:0] flash_addr_i,
    input wire        flash_go_o,
    input wire        flash_refuse_o
);
    wire        in_region = flash_addr_i[31:24] == `FPWP_FLASH_REGION;
    reg         rd_prot;
    reg         locked_seen;
    reg  [31:0] last_prot;
    always @(posedge mclk_i or negedge reset_n_i)
        if (!reset_n_i)
        begin
            rd_prot     <= 1'b0;
            locked_seen <= 1'b0;
            last_prot   <= 32'h00000000;
        end
        else
        begin
            rd_prot <= reg_rd_i && reg_addr_i == `FPWP_OFS_PROTECT;
            if (rd_prot)
                last_prot <= reg_rdata_o;
            if (rd_prot && !reg_rdata_o[31])
                locked_seen <= 1'b1;
        end
    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (!reset_n_i);
    property p_go_cause; flash_go_o |-> $past(flash_req_i); endproperty
    property p_one_answer; flash_req_i |=> flash_go_o ^ flash_refuse_o; endproperty
    property p_excl; !(flash_go_o && flash_refuse_o); endproperty
    property p_ref_region; flash_refuse_o |-> $past(flash_req_i) && $past(in_region); endproperty
    property p_out_go; flash_req_i && !in_region |=> flash_go_o; endproperty
    property p_unimpl; rd_prot |-> reg_rdata_o[30:24] == 7'h00; endproperty
    property p_frozen; rd_prot && locked_seen |-> reg_rdata_o == last_prot; endproperty
    property p_sticky; rd_prot && locked_seen |-> !reg_rdata_o[31]; endproperty
    a_go_cause: assert property (p_go_cause)
        else $error("go without request");
    a_one_answer: assert property (p_one_answer)
        else $error("request not answered once");
    a_excl: assert property (p_excl)
        else $error("go and refuse together");
    a_ref_region: assert property (p_ref_region)
        else $error("refuse outside flash region");
    a_out_go: assert property (p_out_go)
        else $error("outside address not allowed");
    a_unimpl: assert property (p_unimpl)
        else $error("unimplemented bits not zero");
    a_frozen: assert property (p_frozen)
        else $error("locked register changed");
    a_sticky: assert property (p_sticky)
        else $error("unlock bit set again");
    c_refuse: cover property (flash_refuse_o);
    c_frozen: cover property (rd_prot && locked_seen);
    c_go_region: cover property (flash_go_o && $past(in_region));
endmodule
bind fpwp_ctrl fpwp_ctrl_properties fpwp_ctrl_properties_i (.mclk_i(mclk_i),
    .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .flash_req_i(flash_req_i),
    .flash_addr_i(flash_addr_i), .flash_go_o(flash_go_o),
    .flash_refuse_o(flash_refuse_o));

// *** tb/test_flash_page_write_protect.sv ***
/*
 Self-checking bench for fpwp_ctrl against an integer model of the rules.
 Assumes the offsets and key words of fpwp_map.vh.
*/
`timescale 1ns/1ps
`include "fpwp_map.vh"
module test_flash_page_write_protect;
    reg         mclk_i = 0, reset_n_i = 0, wr = 0, rd = 0, fq = 0, fe = 0;
    reg  [7:0]  ad = 0;
    reg  [31:0] wd = 0, fa = 0, rs = 18, r;
    reg  [9:0]  pg;
    wire [31:0] rdt;
    wire        go, rf;
    integer     lk, bnd, op, k1, er, ek, fad, i, mismatches = 0, n_checks = 0;
    fpwp_ctrl fpwp_ctrl_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .reg_addr_i(ad),
        .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdt),
        .flash_req_i(fq), .flash_erase_i(fe), .flash_addr_i(fa),
        .flash_go_o(go), .flash_refuse_o(rf));
    always #50 mclk_i = ~mclk_i;
    function [31:0] xs;
    begin
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        xs = rs;
    end
    endfunction
    task chk(input [31:0] s, input [31:0] e);
    begin
        n_checks = n_checks + 1;
        if (s !== e)
        begin
            mismatches = mismatches + 1;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    end
    endtask
    task mrst;
    begin
        lk = 1; bnd = 0; op = 0; k1 = 0; er = 0; ek = 0; fad = 0;
    end
    endtask
    task wrt(input [7:0] x, input [31:0] d);
    begin
        @(posedge mclk_i);
        ad <= x;
        wd <= d;
        wr <= 1'b1;
        if (x == `FPWP_OFS_PROTECT && op && lk)
        begin
            lk = lk & d[31];
            bnd = d[23:14];
        end
        if (x == `FPWP_OFS_STATUS && d[0])
            er = 0;
        op = x == `FPWP_OFS_KEY && k1 && d == `FPWP_KEY_SECOND;
        k1 = x == `FPWP_OFS_KEY && d == `FPWP_KEY_FIRST;
        @(posedge mclk_i);
        wr <= 1'b0;
    end
    endtask
    task rdc(input [7:0] x);
        reg [31:0] e;
    begin
        case (x)
            `FPWP_OFS_PROTECT: e = {lk[0], 7'h00, bnd[9:0], 14'h0000};
            `FPWP_OFS_STATUS:  e = {29'h00000000, ek[0], op[0], er[0]};
            `FPWP_OFS_FAULT:   e = fad;
            default:           e = 32'h00000000;
        endcase
        @(posedge mclk_i);
        ad <= x;
        rd <= 1'b1;
        @(posedge mclk_i);
        rd <= 1'b0;
        #1 chk(rdt, e);
    end
    endtask
    task fl(input [31:0] x, input k);
        reg p;
    begin
        p = bnd != 0 && x[31:24] == `FPWP_FLASH_REGION && x[23:14] <= bnd;
        @(posedge mclk_i);
        fq <= 1'b1;
        fa <= x;
        fe <= k;
        @(posedge mclk_i);
        fq <= 1'b0;
        #1 chk({go, rf}, {!p, p});
        if (p)
        begin
            er = 1; ek = k; fad = x;
        end
    end
    endtask
    task unl;
    begin
        wrt(`FPWP_OFS_KEY, `FPWP_KEY_FIRST);
        wrt(`FPWP_OFS_KEY, `FPWP_KEY_SECOND);
    end
    endtask
    task report_and_stop;
    begin
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    end
    endtask
    initial
    begin
        repeat (90000) @(posedge mclk_i);
        mismatches = mismatches + 1;
        report_and_stop;
    end
    initial
    begin
        mrst;
        repeat (20) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        for (i = 0; i < 5; i = i + 1)
            rdc(i * 4);
        fl({8'h1D, 24'h000000}, 1'b0);
        wrt(`FPWP_OFS_PROTECT, 32'h00FFC000);
        rdc(`FPWP_OFS_PROTECT);
        unl;
        rdc(`FPWP_OFS_STATUS);
        wrt(`FPWP_OFS_PROTECT, xs() | 32'h80004000);
        rdc(`FPWP_OFS_PROTECT);
        for (i = 0; i < 24; i = i + 1)
        begin
            r = xs();
            // page one below, at and one above the boundary, held to the 10-bit field
            pg = 10'(bnd + i % 3 - 1);
            fl({(i % 4) ? 8'h1D : r[31:24], pg, r[13:0]}, r[0]);
        end
        rdc(`FPWP_OFS_STATUS);
        rdc(`FPWP_OFS_FAULT);
        wrt(`FPWP_OFS_STATUS, 32'h00000001);
        rdc(`FPWP_OFS_STATUS);
        unl;
        wrt(`FPWP_OFS_STATUS, 32'h00000000);
        wrt(`FPWP_OFS_PROTECT, 32'h80000000);
        rdc(`FPWP_OFS_PROTECT);
        unl;
        wrt(`FPWP_OFS_PROTECT, 32'h00FFC000);
        rdc(`FPWP_OFS_PROTECT);
        unl;
        wrt(`FPWP_OFS_PROTECT, 32'hFFFFFFFF);
        rdc(`FPWP_OFS_PROTECT);
        fl(32'h1DFFFFFF, 1'b1);
        // a refuse in the same cycle as the clear must leave the error set
        fork
            wrt(`FPWP_OFS_STATUS, 32'h00000001);
            fl(32'h1D000000, 1'b0);
        join
        rdc(`FPWP_OFS_STATUS);
        rdc(`FPWP_OFS_FAULT);
        @(posedge mclk_i);
        reset_n_i <= 1'b0;
        mrst;
        repeat (3) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        rdc(`FPWP_OFS_PROTECT);
        report_and_stop;
    end
endmodule
